// ---- cwr_pkg.sv ----
package cwr_pkg;

  // Configuration word geometry
  localparam int          CFG_W         = 14;
  localparam logic [13:0] CFG_ADDR      = 14'h2007;
  localparam logic [13:0] CFG_ERASED    = 14'h3FFF;
  localparam logic [13:0] CFG_FORCE_ONE = 14'h0080;
  localparam int          BIT_OSC_LO    = 0;
  localparam int          BIT_OSC_HI    = 1;
  localparam int          BIT_WDT_EN    = 2;
  localparam int          BIT_POWERUP_DELAY_TIMER_EN_N = 3;
  localparam int          BIT_PAIR0_LO  = 4;
  localparam int          BIT_BOR_EN    = 6;
  localparam int          BIT_PAIR1_LO  = 8;
  localparam int          BIT_PAIR2_LO  = 10;
  localparam int          BIT_PAIR3_LO  = 12;

  // Oscillator select codes
  localparam logic [1:0] OSC_LOW_POWER   = 2'h0;
  localparam logic [1:0] OSC_STD_CRYSTAL = 2'h1;
  localparam logic [1:0] OSC_HIGH_SPEED  = 2'h2;
  localparam logic [1:0] OSC_RES_CAP     = 2'h3;

  // Code protection levels, same code as a protect pair
  localparam logic [1:0] PROT_ALL     = 2'h0;
  localparam logic [1:0] PROT_UPPER34 = 2'h1;
  localparam logic [1:0] PROT_UPPER12 = 2'h2;
  localparam logic [1:0] PROT_NONE    = 2'h3;

  // Timing
  localparam int CLK_KHZ              = 125000;
  localparam int POWERUP_DELAY_MS     = 72;
  localparam int POWERUP_DELAY_CYCLES = POWERUP_DELAY_MS * CLK_KHZ;
  localparam int OSC_STARTUP_CYCLES   = 1024;
  localparam int WDT_TIMEOUT_TICKS    = 256;
  localparam int CNT_W                = 24;
  localparam int WDT_W                = 16;

  // Synchroniser bus layout and reset value (external reset idle high)
  localparam int          SYNC_W   = 34;
  localparam logic [33:0] SYNC_RST = 34'h0_0000_0002;

  typedef struct packed {
    logic [1:0] protect;
    logic       bor_en;
    logic       powerup_delay_timer_en;
    logic       wdt_en;
    logic [1:0] osc_mode;
  } cwr_cfg_t;

  typedef struct packed {
    logic        prog_mode;
    logic        prog_wr;
    logic        prog_rd;
    logic [13:0] prog_addr;
    logic [13:0] prog_data;
    logic        brownout;
    logic        ext_resetn;
    logic        wdt_osc;
  } cwr_pins_t;

  typedef enum logic [2:0] {
    ST_POR,
    ST_POWERUP_DELAY_TIMER,
    ST_OST,
    ST_RUN,
    ST_SLEEP,
    ST_HOLD
  } cwr_state_t;

endpackage

// ---- cwr_config_reset.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwr_config_reset
  import cwr_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_DELAY_CYCLES,
  parameter int OST_CYCLES     = OSC_STARTUP_CYCLES,
  parameter int WDT_TICKS      = WDT_TIMEOUT_TICKS
) (
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        PROG_MODE_IN,
  input  wire logic        PROG_WR_IN,
  input  wire logic        PROG_RD_IN,
  input  wire logic [13:0] PROG_ADDR_IN,
  input  wire logic [13:0] PROG_WDATA_IN,
  input  wire logic        BROWNOUT_IN,
  input  wire logic        EXT_RESETN_IN,
  input  wire logic        WDT_OSC_IN,
  input  wire logic        SLEEP_REQ_IN,
  input  wire logic        WDT_CLEAR_IN,
  input  wire logic        INTERRUPT_IN,
  output var  logic [13:0] PROG_RDATA_OUT,
  output var  logic        CORE_RESET_OUT,
  output var  logic        SLEEP_OUT,
  output var  logic        WAKE_OUT,
  output var  logic        WDT_TIMEOUT_OUT,
  output var  logic [1:0]  OSC_MODE_OUT,
  output var  logic [1:0]  PROTECT_LEVEL_OUT,
  output var  logic        BROWNOUT_EN_OUT,
  output var  logic        WDT_EN_OUT
);

  // Erased bits read 1, so each enable below is keyed on the raw level, except the power-up delay timer's, which is keyed on the inverted bit 3
  function automatic cwr_cfg_t decode_cfg(input logic [13:0] w);
    cwr_cfg_t   d;
    logic [1:0] p0;
    p0 = w[BIT_PAIR0_LO +: 2];
    d.protect = PROT_NONE;
    // Mixed pairs select no scheme, so nothing is protected
    if (w[BIT_PAIR1_LO +: 2] == p0 && w[BIT_PAIR2_LO +: 2] == p0 &&
        w[BIT_PAIR3_LO +: 2] == p0) begin
      d.protect = p0;
    end
    d.bor_en   = w[BIT_BOR_EN];
    d.powerup_delay_timer_en  = ~w[BIT_POWERUP_DELAY_TIMER_EN_N];
    d.wdt_en   = w[BIT_WDT_EN];
    d.osc_mode = {w[BIT_OSC_HI], w[BIT_OSC_LO]};
    return d;
  endfunction

  function automatic logic is_crystal(input logic [1:0] m);
    return m != OSC_RES_CAP;
  endfunction

  // Pin synchronisers
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync1_next;
  logic [SYNC_W-1:0] sync2_next;
  logic              wr_prev_reg;
  logic              osc_prev_reg;
  logic              wr_prev_next;
  logic              osc_prev_next;
  cwr_pins_t         pins;

  always_comb begin
    sync1_next    = {PROG_MODE_IN, PROG_WR_IN, PROG_RD_IN, PROG_ADDR_IN,
                     PROG_WDATA_IN, BROWNOUT_IN, EXT_RESETN_IN, WDT_OSC_IN};
    sync2_next    = sync1_reg;
    pins          = cwr_pins_t'(sync2_reg);
    wr_prev_next  = pins.prog_wr;
    osc_prev_next = pins.wdt_osc;
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync1_reg    <= SYNC_RST;
      sync2_reg    <= SYNC_RST;
      wr_prev_reg  <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= sync1_next;
      sync2_reg    <= sync2_next;
      wr_prev_reg  <= wr_prev_next;
      osc_prev_reg <= osc_prev_next;
    end
  end

  logic wr_rise;
  logic osc_tick;
  logic addr_hit;
  assign wr_rise  = pins.prog_wr & ~wr_prev_reg;
  assign osc_tick = pins.wdt_osc & ~osc_prev_reg;
  assign addr_hit = pins.prog_mode && pins.prog_addr == CFG_ADDR;

  // Configuration word store, an EPROM: programming only clears bits
  logic [13:0] cfg_reg;
  logic [13:0] cfg_next;
  logic [13:0] rdata_next;
  cwr_cfg_t    dec;

  always_comb begin
    cfg_next   = cfg_reg;
    rdata_next = 14'h0000;
    if (addr_hit && wr_rise) begin
      cfg_next = (cfg_reg & pins.prog_data) | CFG_FORCE_ONE;
    end
    if (addr_hit && pins.prog_rd) begin
      rdata_next = cfg_reg | CFG_FORCE_ONE;
    end
    dec = decode_cfg(cfg_reg);
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cfg_reg        <= CFG_ERASED;
      PROG_RDATA_OUT <= 14'h0000;
    end else begin
      cfg_reg        <= cfg_next;
      PROG_RDATA_OUT <= rdata_next;
    end
  end

  // Watchdog: no core input can stop it, only the enable bit
  logic [WDT_W-1:0] wdt_cnt_reg;
  logic [WDT_W-1:0] wdt_cnt_next;
  logic             wdt_to_next;
  cwr_state_t       state_reg;

  always_comb begin
    wdt_cnt_next = wdt_cnt_reg;
    wdt_to_next  = 1'b0;
    if (!dec.wdt_en) begin
      wdt_cnt_next = '0;
    end else if (WDT_CLEAR_IN ||
                 (state_reg == ST_RUN && SLEEP_REQ_IN)) begin
      wdt_cnt_next = '0;
    end else if (osc_tick) begin
      if (wdt_cnt_reg == WDT_W'(WDT_TICKS - 1)) begin
        wdt_cnt_next = '0;
        wdt_to_next  = 1'b1;
      end else begin
        wdt_cnt_next = wdt_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wdt_cnt_reg     <= '0;
      WDT_TIMEOUT_OUT <= 1'b0;
    end else begin
      wdt_cnt_reg     <= wdt_cnt_next;
      WDT_TIMEOUT_OUT <= wdt_to_next;
    end
  end

  // Reset and sleep sequencer
  cwr_state_t       state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             wake_next;
  logic             bor_hit;
  logic             powerup_delay_timer_active;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 1'b1;
    wake_next  = 1'b0;
    bor_hit     = pins.brownout && dec.bor_en;
    // Brown-out reset forces the power-up delay whatever its own bit says
    powerup_delay_timer_active = dec.powerup_delay_timer_en || dec.bor_en;
    case (state_reg)
      ST_POR: begin
        cnt_next = '0;
        if (powerup_delay_timer_active) begin
          state_next = ST_POWERUP_DELAY_TIMER;
        end else if (is_crystal(dec.osc_mode)) begin
          state_next = ST_OST;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_POWERUP_DELAY_TIMER: begin
        if (cnt_reg == CNT_W'(POWERUP_CYCLES - 1)) begin
          cnt_next   = '0;
          state_next = is_crystal(dec.osc_mode) ? ST_OST : ST_RUN;
        end
      end
      ST_OST: begin
        if (cnt_reg == CNT_W'(OST_CYCLES - 1)) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wdt_to_next) begin
          state_next = ST_HOLD;
        end else if (SLEEP_REQ_IN) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        cnt_next = '0;
        // Oscillator was stopped, so a crystal must settle again
        if (INTERRUPT_IN || wdt_to_next) begin
          wake_next  = 1'b1;
          state_next = is_crystal(dec.osc_mode) ? ST_OST : ST_RUN;
        end
      end
      ST_HOLD: begin
        if (pins.ext_resetn) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
    // External reset outranks everything except brown-out
    if (!pins.ext_resetn) begin
      wake_next  = (state_reg == ST_SLEEP);
      state_next = ST_HOLD;
    end
    if (bor_hit) begin
      wake_next  = 1'b0;
      state_next = ST_POR;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_reg         <= ST_POR;
      cnt_reg           <= '0;
      CORE_RESET_OUT    <= 1'b1;
      SLEEP_OUT         <= 1'b0;
      WAKE_OUT          <= 1'b0;
      OSC_MODE_OUT      <= OSC_RES_CAP;
      PROTECT_LEVEL_OUT <= PROT_NONE;
      BROWNOUT_EN_OUT   <= 1'b1;
      WDT_EN_OUT        <= 1'b1;
    end else begin
      state_reg         <= state_next;
      cnt_reg           <= cnt_next;
      CORE_RESET_OUT    <= state_next != ST_RUN && state_next != ST_SLEEP;
      SLEEP_OUT         <= state_next == ST_SLEEP;
      WAKE_OUT          <= wake_next;
      OSC_MODE_OUT      <= dec.osc_mode;
      PROTECT_LEVEL_OUT <= dec.protect;
      BROWNOUT_EN_OUT   <= dec.bor_en;
      WDT_EN_OUT        <= dec.wdt_en;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_wdt_bit_off: assert property (
    !cfg_reg[BIT_WDT_EN] |=> !WDT_TIMEOUT_OUT)
    else $error("watchdog timed out while disabled");
  a_wdt_rc_only: assert property (
    !osc_tick && !WDT_CLEAR_IN && dec.wdt_en && !SLEEP_REQ_IN
      |=> $stable(wdt_cnt_reg))
    else $error("watchdog moved without an RC tick");
  a_ost_hold_reset: assert property (
    state_reg == ST_OST |-> CORE_RESET_OUT)
    else $error("core released during start-up timer");
  a_powerup_delay_timer_skipped: assert property (
    state_reg == ST_POR && !bor_hit && pins.ext_resetn &&
      cfg_reg[BIT_POWERUP_DELAY_TIMER_EN_N] && !cfg_reg[BIT_BOR_EN]
      |=> state_reg != ST_POWERUP_DELAY_TIMER)
    else $error("power-up timer ran while disabled");
  a_sleep_irq_wake: assert property (
    state_reg == ST_SLEEP && INTERRUPT_IN |=> WAKE_OUT ##1 !SLEEP_OUT)
    else $error("interrupt did not end sleep");
  a_erased_reads: assert property (
    cfg_reg == CFG_ERASED |=> PROTECT_LEVEL_OUT == PROT_NONE &&
      WDT_EN_OUT && BROWNOUT_EN_OUT && OSC_MODE_OUT == OSC_RES_CAP)
    else $error("erased word decoded wrongly");
  a_read_prog_only: assert property (
    !pins.prog_mode |=> PROG_RDATA_OUT == 14'h0000)
    else $error("configuration word read outside programming mode");
  a_protect_all: assert property (
    cfg_reg[13:8] == 6'h00 && cfg_reg[5:4] == 2'h0
      |=> PROTECT_LEVEL_OUT == PROT_ALL)
    else $error("all-zero pairs did not protect all memory");
  a_bit7_one: assert property (
    addr_hit && pins.prog_rd |=> PROG_RDATA_OUT[7])
    else $error("bit 7 read as zero");
  a_bor_disabled: assert property (
    state_reg == ST_RUN && !cfg_reg[BIT_BOR_EN] && pins.ext_resetn &&
      !wdt_to_next && !SLEEP_REQ_IN |=> state_reg == ST_RUN)
    else $error("brown-out reset while disabled");
  a_osc_follow: assert property (
    ##1 $stable(cfg_reg) |=> OSC_MODE_OUT == $past(cfg_reg[1:0], 2))
    else $error("oscillator mode does not follow bits 1-0");

endmodule
`default_nettype wire

// ---- cwr_programmer.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwr_programmer (
  input  wire logic        clk_in,
  input  wire logic [13:0] rdata_in,
  output var  logic        mode_out,
  output var  logic        wr_out,
  output var  logic        rd_out,
  output var  logic [13:0] addr_out,
  output var  logic [13:0] data_out
);
  initial begin
    mode_out = 1'b0;
    wr_out   = 1'b0;
    rd_out   = 1'b0;
    addr_out = 14'h0000;
    data_out = 14'h2AAA;
  end
  // Same code into every protect pair, else the scheme is not honoured
  function automatic logic [13:0] pack(input logic [1:0] p,
    input logic b, input logic t, input logic g, input logic [1:0] o);
    return {p, p, p, 1'b1, b, p, t, g, o};
  endfunction
  // Strobe held 4 cycles then 4 idle, to cover the pin synchronisers
  task automatic write(input logic [13:0] a, input logic [13:0] d,
    input logic m);
    @(posedge clk_in);
    #1;
    mode_out = m;
    addr_out = a;
    data_out = d;
    wr_out   = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    wr_out   = 1'b0;
    mode_out = 1'b0;
    // Released lines must not keep showing the last word
    data_out = ~d;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic read(input logic [13:0] a, input logic m,
    output logic [13:0] d);
    @(posedge clk_in);
    #1;
    mode_out = m;
    addr_out = a;
    rd_out   = 1'b1;
    repeat (5) @(posedge clk_in);
    d = rdata_in;
    #1;
    rd_out   = 1'b0;
    mode_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- config_word_reset_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module config_word_reset_control_bench;
  import cwr_pkg::*;
  localparam int PWC  = 20;
  localparam int OSTC = 8;
  localparam int WDTT = 4;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        bo, extn, wosc, slp, wclr, irq, pm, pw, pr;
  logic        rst_o, slp_o, wake_o, tmo_o, bor_o, wdt_o;
  logic [1:0]  osc_o, prot_o;
  logic [13:0] pa, pd, rdat, d, w;
  logic [31:0] rs = 32'h0000_5809;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n, n_wake = 0, n_tmo = 0;
  always #4 clk = ~clk;
  cwr_config_reset #(
    .POWERUP_CYCLES(PWC),
    .OST_CYCLES    (OSTC),
    .WDT_TICKS     (WDTT)
  ) uut (
    .CLK_IN           (clk),
    .RESETN_IN        (rstn),
    .PROG_MODE_IN     (pm),
    .PROG_WR_IN       (pw),
    .PROG_RD_IN       (pr),
    .PROG_ADDR_IN     (pa),
    .PROG_WDATA_IN    (pd),
    .BROWNOUT_IN      (bo),
    .EXT_RESETN_IN    (extn),
    .WDT_OSC_IN       (wosc),
    .SLEEP_REQ_IN     (slp),
    .WDT_CLEAR_IN     (wclr),
    .INTERRUPT_IN     (irq),
    .PROG_RDATA_OUT   (rdat),
    .CORE_RESET_OUT   (rst_o),
    .SLEEP_OUT        (slp_o),
    .WAKE_OUT         (wake_o),
    .WDT_TIMEOUT_OUT  (tmo_o),
    .OSC_MODE_OUT     (osc_o),
    .PROTECT_LEVEL_OUT(prot_o),
    .BROWNOUT_EN_OUT  (bor_o),
    .WDT_EN_OUT       (wdt_o)
  );
  cwr_programmer prog (
    .clk_in  (clk),
    .rdata_in(rdat),
    .mode_out(pm),
    .wr_out  (pw),
    .rd_out  (pr),
    .addr_out(pa),
    .data_out(pd)
  );
  always @(posedge clk) begin
    if (wake_o === 1'b1) n_wake++;
    if (tmo_o === 1'b1) n_tmo++;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Mismatched pairs fall back to no protection
  function automatic logic [1:0] pr_of(input logic [13:0] c);
    if (c[13:12] == c[5:4] && c[11:10] == c[5:4] && c[9:8] == c[5:4]) begin
      return c[5:4];
    end
    return PROT_NONE;
  endfunction
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [13:0] g, input logic [13:0] e,
    input string m);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic hold(output int k);
    k = 0;
    while (rst_o !== 1'b0 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    #1;
  endtask
  task automatic por(output int k);
    cyc(1);
    rstn = 1'b0;
    cyc(16);
    rstn = 1'b1;
    hold(k);
  endtask
  task automatic tick(input int t);
    repeat (t) begin
      cyc(3);
      wosc = 1'b1;
      cyc(3);
      wosc = 1'b0;
    end
  endtask
  task automatic dec(input logic [13:0] c);
    chk(14'(osc_o), 14'(c[1:0]), "osc mode");
    chk(14'(prot_o), 14'(pr_of(c)), "protect");
    chk(14'(bor_o), 14'(c[6]), "brownout enable");
    chk(14'(wdt_o), 14'(c[2]), "watchdog enable");
  endtask
  initial begin
    #400_000;
    n_mismatch++;
    conclude();
  end
  initial begin
    {bo, slp, wclr, irq, wosc} = 5'h00;
    extn = 1'b1;
    por(n);
    chk(14'(n >= PWC && n <= PWC + 4), 14'h0001, "power-up hold");
    dec(CFG_ERASED);
    prog.read(CFG_ADDR, 1'b1, d);
    chk(d, CFG_ERASED, "erased word");
    prog.read(14'h2006, 1'b1, d);
    chk(d, 14'h0000, "other address");
    prog.write(CFG_ADDR, 14'h0000, 1'b0);
    prog.read(CFG_ADDR, 1'b0, d);
    chk(d, 14'h0000, "read outside programming");
    prog.read(CFG_ADDR, 1'b1, d);
    chk(d, CFG_ERASED, "write outside programming");
    for (int i = 0; i < 8; i++) begin
      por(n);
      rs = xs(rs);
      w = rs[13:0];
      w[1:0] = 2'(i);
      if (i < 4) w = prog.pack(w[5:4], w[6], w[3], w[2], w[1:0]);
      prog.write(CFG_ADDR, w, 1'b1);
      w = w | CFG_FORCE_ONE;
      dec(w);
      prog.read(CFG_ADDR, 1'b1, d);
      chk(d, w, "read back");
      rs = xs(rs);
      prog.write(CFG_ADDR, rs[13:0], 1'b1);
      w = w & (rs[13:0] | CFG_FORCE_ONE);
      dec(w);
    end
    por(n);
    prog.write(CFG_ADDR, 14'h3FF9, 1'b1);
    bo = 1'b1;
    cyc(4);
    chk(14'(rst_o), 14'h0001, "brownout reset");
    bo = 1'b0;
    hold(n);
    chk(14'(n >= PWC + OSTC && n <= PWC + OSTC + 6), 14'h0001,
      "crystal start-up hold");
    prog.write(CFG_ADDR, 14'h3FB9, 1'b1);
    bo = 1'b1;
    cyc(4);
    bo = 1'b0;
    chk(14'(rst_o), 14'h0000, "brownout disabled");
    tick(2 * WDTT);
    chk(14'(n_tmo), 14'h0000, "watchdog off");
    por(n);
    cyc(60);
    chk(14'(n_tmo), 14'h0000, "core clock not counted");
    tick(WDTT - 1);
    wclr = 1'b1;
    cyc(1);
    wclr = 1'b0;
    tick(WDTT - 1);
    chk(14'(n_tmo), 14'h0000, "watchdog cleared");
    tick(1);
    cyc(4);
    chk(14'(n_tmo), 14'h0001, "watchdog expiry");
    hold(n);
    slp = 1'b1;
    cyc(1);
    slp = 1'b0;
    cyc(2);
    chk(14'(slp_o), 14'h0001, "sleep entry");
    irq = 1'b1;
    cyc(1);
    irq = 1'b0;
    cyc(3);
    chk(14'(n_wake), 14'h0001, "interrupt wake");
    chk(14'(slp_o), 14'h0000, "awake");
    slp = 1'b1;
    cyc(1);
    slp = 1'b0;
    tick(WDTT);
    cyc(3);
    chk(14'(n_wake), 14'h0002, "watchdog wake");
    slp = 1'b1;
    cyc(1);
    slp = 1'b0;
    cyc(2);
    extn = 1'b0;
    cyc(4);
    chk(14'(n_wake), 14'h0003, "external reset wake");
    chk(14'(rst_o), 14'h0001, "external reset holds");
    extn = 1'b1;
    cyc(4);
    conclude();
  end
endmodule
`default_nettype wire
